// ==== tap_consts.vh ====
`ifndef TAP_CONSTS_VH
`define TAP_CONSTS_VH
// Instruction register width and codes.
`define IR_W 3
`define IR_EXTEST 3'h0
`define IR_IDENT 3'h1
`define IR_SAMPLE 3'h2
`define IR_CLAMP 3'h3
`define IR_HIGHZ 3'h4
`define IR_BYPASS 3'h7
// Fixed capture pattern, low two bits 01.
`define IR_CAPTURE 3'h1
// Identification register layout.
`define ID_W 32
`define ID_REQ_BIT 1'b1
// Arbitrary neutral identity values.
`define ID_MFR 11'h155
`define ID_PART 16'h1234
`define ID_VER 4'h1
// Boundary-scan pin count; the register holds two cells per pin.
`define BSR_W 8
// Controller state count (one-hot).
`define NST 16
`endif

// ==== tap_bsr_cell.v ====
`timescale 1ns/1ps
`default_nettype none
`include "tap_consts.vh"
// One boundary-scan cell: shift stage plus latched parallel output.
module tap_bsr_cell (
  // Clock and reset.
  input wire ref_clk_in,
  input wire rst_n_in,
  // Control strobes.
  input wire capture_in,
  input wire shift_in,
  input wire update_in,
  // Data.
  input wire pin_in,
  input wire scan_in,
  output wire shift_out,
  output wire latch_out
);
  reg shift_q; // Shift stage, part of the serial chain.
  reg latch_q; // Parallel stage, the value the pads may see.
  assign shift_out = shift_q;
  assign latch_out = latch_q;
  // Shift stage captures the pin or takes the neighbour's bit.
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      shift_q <= 1'b0;
    end else if (capture_in) begin
      shift_q <= pin_in;
    end else if (shift_in) begin
      shift_q <= scan_in;
    end
  end
  // Parallel stage only moves at update so shifting never disturbs it.
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      latch_q <= 1'b0;
    end else if (update_in) begin
      latch_q <= shift_q;
    end
  end
endmodule
`default_nettype wire

// ==== boundary_scan_test_port.v ====
`timescale 1ns/1ps
`default_nettype none
`include "tap_consts.vh"
// Notes on behaviour
// - Controller steps on test clock rise by mode
// - Three-bit instruction shift and parallel stages
// - Shift-IR moves instruction bits toward output
// - Exit state with mode high enters update
// - Falling edge in update state loads instruction
// - Code 010 samples and loads boundary scan
// - Code 111 uses one-bit bypass path
// - Code 000 drives pins from boundary scan
// - Code 011 clamps outputs, bypass in path
// - Code 100 floats outputs, bypass in path
// - Code 001 captures and shifts identification
// - Test-logic-reset forces identification instruction
// - Identification layout: one, maker, part, version
// - Identification has shift and parallel stages
// - Boundary cell per control and I/O
// - Instruction capture loads low bits 01
// - Test reset clears logic asynchronously
module boundary_scan_test_port (
  // System clock and reset.
  input wire ref_clk_in,
  input wire resetn_in,
  // Tester pins.
  input wire test_clock_in,
  input wire test_mode_select_in,
  input wire test_serial_in,
  input wire test_reset_n,
  output reg test_serial_out,
  output reg test_serial_oe_out,
  // Core pins seen by the boundary cells.
  input wire [`BSR_W-1:0] core_out_in,
  input wire [`BSR_W-1:0] core_oe_in,
  input wire [`BSR_W-1:0] pad_in,
  output reg [`BSR_W-1:0] pad_out,
  output reg [`BSR_W-1:0] pad_oe_out,
  // Current instruction, for observation.
  output reg [`IR_W-1:0] instr_out
);
  // ----------------------------------------------------------------
  // Controller states, one-hot.
  // ----------------------------------------------------------------
  localparam [15:0] S_TLR = 16'h0001;
  localparam [15:0] S_RTI = 16'h0002;
  localparam [15:0] S_SDR = 16'h0004;
  localparam [15:0] S_CDR = 16'h0008;
  localparam [15:0] S_SHDR = 16'h0010;
  localparam [15:0] S_E1DR = 16'h0020;
  localparam [15:0] S_PDR = 16'h0040;
  localparam [15:0] S_E2DR = 16'h0080;
  localparam [15:0] S_UDR = 16'h0100;
  localparam [15:0] S_SIR = 16'h0200;
  localparam [15:0] S_CIR = 16'h0400;
  localparam [15:0] S_SHIR = 16'h0800;
  localparam [15:0] S_E1IR = 16'h1000;
  localparam [15:0] S_PIR = 16'h2000;
  localparam [15:0] S_E2IR = 16'h4000;
  localparam [15:0] S_UIR = 16'h8000;
  localparam [`ID_W-1:0] ID_VALUE = {`ID_VER, `ID_PART, `ID_MFR,
    `ID_REQ_BIT};

  // ----------------------------------------------------------------
  // Pin synchronisers.
  // ----------------------------------------------------------------
  // Either reset pin clears the test logic at once, with no clock edge
  // needed. Release is retimed through two flops so that no register
  // leaves reset on a different system edge from its neighbours.
  wire rst_raw_n;
  assign rst_raw_n = resetn_in & test_reset_n;
  reg rst_s1_q; // First reset stage; read only by the second.
  reg rst_s2_q; // Second reset stage, drives every clear below.
  always @(posedge ref_clk_in or negedge rst_raw_n) begin
    if (!rst_raw_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  wire rst_n;
  assign rst_n = rst_s2_q;
  reg [2:0] sync1_q; // First stage; read only by second stage.
  reg [2:0] sync2_q; // Second stage, safe to use.
  reg tck_d1_q; // Previous synchronised clock level.
  // The tester's clock is only sampled here, so each of its levels must
  // last several system cycles or an edge is lost.
  always @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
      tck_d1_q <= 1'b0;
    end else begin
      sync1_q <= {test_clock_in, test_mode_select_in, test_serial_in};
      sync2_q <= sync1_q;
      tck_d1_q <= sync2_q[2];
    end
  end
  wire tck_s = sync2_q[2];
  wire tms_s = sync2_q[1];
  wire tdi_s = sync2_q[0];
  // Pads are sampled twice before the boundary cells may capture them.
  reg [`BSR_W-1:0] pad_s1_q; // First pad stage; read only by the second.
  reg [`BSR_W-1:0] pad_s2_q; // Second pad stage, read by the cells.
  always @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pad_s1_q <= {`BSR_W{1'b0}};
      pad_s2_q <= {`BSR_W{1'b0}};
    end else begin
      pad_s1_q <= pad_in;
      pad_s2_q <= pad_s1_q;
    end
  end
  wire rise = tck_s & ~tck_d1_q; // Rising test clock edge.
  wire fall = ~tck_s & tck_d1_q; // Falling test clock edge.

  // ----------------------------------------------------------------
  // Controller.
  // ----------------------------------------------------------------
  reg [15:0] st_q;
  reg [15:0] st_d;
  // Next state for the mode level sampled at the rising edge.
  always @* begin
    case (st_q)
      S_TLR: st_d = tms_s ? S_TLR : S_RTI;
      S_RTI: st_d = tms_s ? S_SDR : S_RTI;
      S_SDR: st_d = tms_s ? S_SIR : S_CDR;
      S_CDR: st_d = tms_s ? S_E1DR : S_SHDR;
      S_SHDR: st_d = tms_s ? S_E1DR : S_SHDR;
      S_E1DR: st_d = tms_s ? S_UDR : S_PDR;
      S_PDR: st_d = tms_s ? S_E2DR : S_PDR;
      S_E2DR: st_d = tms_s ? S_UDR : S_SHDR;
      S_UDR: st_d = tms_s ? S_SDR : S_RTI;
      S_SIR: st_d = tms_s ? S_TLR : S_CIR;
      S_CIR: st_d = tms_s ? S_E1IR : S_SHIR;
      S_SHIR: st_d = tms_s ? S_E1IR : S_SHIR;
      S_E1IR: st_d = tms_s ? S_UIR : S_PIR;
      S_PIR: st_d = tms_s ? S_E2IR : S_PIR;
      S_E2IR: st_d = tms_s ? S_UIR : S_SHIR;
      S_UIR: st_d = tms_s ? S_SDR : S_RTI;
      default: st_d = S_TLR;
    endcase
  end
  always @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= S_TLR;
    end else if (rise) begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Instruction register.
  // ----------------------------------------------------------------
  reg [`IR_W-1:0] ir_sh_q; // Shift stage.
  reg [`IR_W-1:0] ir_q; // Current instruction.
  always @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ir_sh_q <= `IR_CAPTURE;
      ir_q <= `IR_IDENT;
    end else begin
      if (rise && st_q == S_CIR) begin
        ir_sh_q <= `IR_CAPTURE;
      end else if (rise && st_q == S_SHIR) begin
        ir_sh_q <= {tdi_s, ir_sh_q[`IR_W-1:1]};
      end
      if (st_q == S_TLR) begin
        ir_q <= `IR_IDENT;
      end else if (fall && st_q == S_UIR) begin
        ir_q <= ir_sh_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Decode.
  // ----------------------------------------------------------------
  // boundary scan selection
  wire sel_bsr = (ir_q == `IR_SAMPLE) | (ir_q == `IR_EXTEST);
  wire sel_id = (ir_q == `IR_IDENT);
  wire sel_byp = ~sel_bsr & ~sel_id;
  // Pads are taken from the boundary latches for these two codes.
  wire drive_bsr = (ir_q == `IR_EXTEST) | (ir_q == `IR_CLAMP);
  // Every pad enable is dropped for this code.
  wire float_all = (ir_q == `IR_HIGHZ);
  // Data strobes, each one system cycle long at a test clock edge.
  wire cap_dr = rise & (st_q == S_CDR);
  wire sh_dr = rise & (st_q == S_SHDR);
  // Update uses the falling edge so the latches never see a half shift.
  wire upd_dr = fall & (st_q == S_UDR);

  // ----------------------------------------------------------------
  // Bypass and identification registers.
  // ----------------------------------------------------------------
  reg byp_q;
  reg [`ID_W-1:0] id_sh_q;
  reg [`ID_W-1:0] id_par_q;
  always @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      byp_q <= 1'b0;
      id_sh_q <= {`ID_W{1'b0}};
      id_par_q <= {`ID_W{1'b0}};
    end else begin
      // Bypass captures zero, then passes the input bit.
      if (sel_byp && cap_dr) begin
        byp_q <= 1'b0;
      end else if (sel_byp && sh_dr) begin
        byp_q <= tdi_s;
      end
      if (sel_id && cap_dr) begin
        id_sh_q <= ID_VALUE;
      end else if (sel_id && sh_dr) begin
        id_sh_q <= {tdi_s, id_sh_q[`ID_W-1:1]};
      end
      if (sel_id && upd_dr) begin
        id_par_q <= id_sh_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Boundary-scan chain, bit 0 nearest the output.
  // ----------------------------------------------------------------
  wire [2*`BSR_W-1:0] bsr_sh;
  wire [2*`BSR_W-1:0] bsr_par;
  wire [2*`BSR_W-1:0] bsr_pin;
  assign bsr_pin = {core_oe_in, sel_bsr && ir_q == `IR_EXTEST ?
    pad_s2_q : core_out_in};
  genvar i;
  generate
    for (i = 0; i < 2*`BSR_W; i = i + 1) begin : g_cell
      tap_bsr_cell u_cell (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n),
        .capture_in(sel_bsr & cap_dr),
        .shift_in(sel_bsr & sh_dr),
        .update_in(sel_bsr & upd_dr),
        .pin_in(bsr_pin[i]),
        .scan_in(i == 2*`BSR_W-1 ? tdi_s : bsr_sh[(i+1)%(2*`BSR_W)]),
        .shift_out(bsr_sh[i]),
        .latch_out(bsr_par[i])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Registered outputs.
  // ----------------------------------------------------------------
  always @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      test_serial_out <= 1'b0;
      test_serial_oe_out <= 1'b0;
      pad_out <= {`BSR_W{1'b0}};
      pad_oe_out <= {`BSR_W{1'b0}};
      instr_out <= `IR_IDENT;
    end else begin
      instr_out <= ir_q;
      // Output changes on falling edge, driven only while shifting.
      if (fall) begin
        test_serial_oe_out <= (st_q == S_SHIR) | (st_q == S_SHDR);
        if (st_q == S_SHIR) begin
          test_serial_out <= ir_sh_q[0];
        end else if (sel_id) begin
          test_serial_out <= id_sh_q[0];
        end else if (sel_bsr) begin
          test_serial_out <= bsr_sh[0];
        end else begin
          test_serial_out <= byp_q;
        end
      end
      // Pads follow the core unless a test instruction owns them; the
      // extra cycle of lag is the cost of registered pad outputs.
      // float all outputs
      if (float_all) begin
        pad_out <= {`BSR_W{1'b0}};
        pad_oe_out <= {`BSR_W{1'b0}};
      end else if (drive_bsr) begin
        pad_out <= bsr_par[`BSR_W-1:0];
        pad_oe_out <= bsr_par[2*`BSR_W-1:`BSR_W];
      end else begin
        pad_out <= core_out_in;
        pad_oe_out <= core_oe_in;
      end
    end
  end
endmodule
`default_nettype wire

// ==== boundary_scan_test_port_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tap_consts.vh"
module port_chk (
  // Clock and resets.
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic test_reset_n,
  // Tester pins.
  input wire logic test_clock_in,
  input wire logic test_serial_out,
  input wire logic test_serial_oe_out,
  // Core, pads and instruction.
  input wire logic [`BSR_W-1:0] core_out_in,
  input wire logic [`BSR_W-1:0] core_oe_in,
  input wire logic [`BSR_W-1:0] pad_out,
  input wire logic [`BSR_W-1:0] pad_oe_out,
  input wire logic [`IR_W-1:0] instr_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);
  // Instructions that leave the pins to the core.
  wire logic norm = test_reset_n && (instr_out == `IR_BYPASS ||
    instr_out == `IR_SAMPLE || instr_out == `IR_IDENT);
  a_reset_ident: assert property (
    !test_reset_n |-> ##1 instr_out == `IR_IDENT) else $error("bad reset");
  a_reset_quiet: assert property (
    !test_reset_n |-> ##1 !test_serial_oe_out) else $error("oe in reset");
  a_highz_float: assert property (
    (instr_out == `IR_HIGHZ)[*3] |-> pad_oe_out == '0) else $error("oe on");
  a_clamp_hold: assert property (
    (instr_out == `IR_CLAMP)[*4] |-> $stable(pad_out) && $stable(pad_oe_out))
    else $error("clamp moved");
  a_core_pass: assert property (
    (norm && $stable(core_out_in) && $stable(core_oe_in))[*4] |->
    pad_out == core_out_in && pad_oe_out == core_oe_in) else $error("pads");
  a_tdo_on_fall: assert property (
    $changed(test_serial_out) && test_reset_n && $past(test_reset_n) |->
    !test_clock_in) else $error("serial out moved with clock high");
  a_instr_on_fall: assert property (
    $changed(instr_out) && instr_out != `IR_IDENT && test_reset_n &&
    $past(test_reset_n) |-> !test_clock_in)
    else $error("instruction moved with clock high");
  a_instr_in_shift: assert property (
    test_serial_oe_out && $past(test_serial_oe_out) |-> $stable(instr_out))
    else $error("instruction moved in shift");
  // Main scenarios reached.
  c_highz: cover property (instr_out == `IR_HIGHZ);
  c_clamp: cover property (instr_out == `IR_CLAMP);
  c_extest: cover property (instr_out == `IR_EXTEST);
  c_shift: cover property ($rose(test_serial_oe_out));
endmodule
bind boundary_scan_test_port port_chk i_chk (
  .ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
  .test_reset_n(test_reset_n), .test_clock_in(test_clock_in),
  .test_serial_out(test_serial_out),
  .test_serial_oe_out(test_serial_oe_out), .core_out_in(core_out_in),
  .core_oe_in(core_oe_in), .pad_out(pad_out), .pad_oe_out(pad_oe_out),
  .instr_out(instr_out)
);
`default_nettype wire

// ==== tap_tester.sv ====
`timescale 1ns/1ps
`default_nettype none
module tap_tester (
  // Pacing clock.
  input wire logic ref_clk_in,
  // Tester pins.
  input wire logic test_serial_out,
  output var logic test_clock_in,
  output var logic test_mode_select_in,
  output var logic test_serial_in,
  output var logic test_reset_n
);
  // The test clock stands low between frames.
  initial begin
    test_clock_in = 1'b0;
    test_mode_select_in = 1'b1;
    test_serial_in = 1'b0;
    test_reset_n = 1'b1;
  end
  // One test clock of 120 ns; serial out is read just before the
  // rise, long after the previous fall moved it.
  task automatic step(input logic m, input logic d, output logic o);
    @(negedge ref_clk_in);
    test_mode_select_in = m;
    test_serial_in = d;
    #56;
    o = test_serial_out;
    test_clock_in = 1'b1;
    #62.5;
    test_clock_in = 1'b0;
  endtask
  // Moves with no data; serial in toggles so it never looks held.
  task automatic idle(input logic m);
    logic o;
    step(m, ~test_serial_in, o);
  endtask
  // Five mode-high edges reach reset, one low edge reaches idle.
  task automatic home();
    repeat (5) idle(1'b1);
    idle(1'b0);
  endtask
  // Test reset pin.
  task automatic set_trst(input logic v);
    @(negedge ref_clk_in);
    test_reset_n = v;
  endtask
  // Whole scan from idle back to idle, data first bit first.
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
    output logic [31:0] dout);
    logic o;
    dout = '0;
    idle(1'b1);
    if (ir) begin
      idle(1'b1);
    end
    idle(1'b0);
    idle(1'b0);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    idle(1'b1);
    idle(1'b0);
  endtask
endmodule
`default_nettype wire

// ==== test_boundary_scan_test_port.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tap_consts.vh"
module test_boundary_scan_test_port;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic ref_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [`BSR_W-1:0] core_out_in = '0, core_oe_in = '0, pad_in = '0;
  wire logic tck, tms, tdi, trst_n, tdo, tdo_oe;
  wire logic [`BSR_W-1:0] pad_out, pad_oe_out;
  wire logic [`IR_W-1:0] instr_out;
  int fails = 0;
  int checked = 0;
  integer seed = 32'hfcc18f81;
  logic [2:0] codes [7] = '{3'h7, 3'h5, 3'h6, 3'h2, 3'h0, 3'h3, 3'h4};
  logic [31:0] din, dout, pre;
  // Bypass model: bits queued in the order the one-bit path passes them.
  bit pipe [$];
  logic [31:0] want;
  localparam logic [31:0] id_exp = {`ID_VER, `ID_PART, `ID_MFR, `ID_REQ_BIT};
  always #5 ref_clk_in = ~ref_clk_in;
  boundary_scan_test_port i_dut (
    .ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
    .test_clock_in(tck), .test_mode_select_in(tms),
    .test_serial_in(tdi), .test_reset_n(trst_n),
    .test_serial_out(tdo), .test_serial_oe_out(tdo_oe),
    .core_out_in(core_out_in), .core_oe_in(core_oe_in), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe_out(pad_oe_out), .instr_out(instr_out)
  );
  tap_tester i_host (
    .ref_clk_in(ref_clk_in), .test_serial_out(tdo), .test_clock_in(tck),
    .test_mode_select_in(tms), .test_serial_in(tdi), .test_reset_n(trst_n)
  );
  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checked %0d, fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // The tests need well under 100 us; a hang is cut off at 500 us.
  initial begin
    #500us;
    fails++;
    $display("FAIL %0t: watchdog expired", $time);
    end_sim();
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    resetn_in = 1'b1;
    i_host.home();
    chk(instr_out, `IR_IDENT);
    din = $random(seed);
    i_host.scan(1'b0, 32, din, dout);
    chk(dout, id_exp);
    $display("ident test done");
    // Each code in turn; the boundary latch model follows in pre.
    foreach (codes[k]) begin
      @(negedge ref_clk_in);
      core_out_in = `BSR_W'($random(seed));
      core_oe_in = `BSR_W'($random(seed));
      pad_in = `BSR_W'($random(seed));
      i_host.scan(1'b1, 3, {29'h0, codes[k]}, dout);
      chk(dout[1:0], 2'b01);
      chk(instr_out, codes[k]);
      if (codes[k] == `IR_EXTEST || codes[k] == `IR_CLAMP) begin
        chk({pad_oe_out, pad_out}, pre[15:0]);
      end
      if (codes[k] == `IR_HIGHZ) begin
        chk(pad_oe_out, 8'h00);
      end
      din = $random(seed);
      i_host.scan(1'b0, 16, din, dout);
      if (codes[k] == `IR_SAMPLE) begin
        chk(dout[7:0], core_out_in);
        pre = din;
      end else if (codes[k] == `IR_EXTEST) begin
        chk(dout[7:0], pad_in);
        chk({pad_oe_out, pad_out}, din[15:0]);
        pre = din;
      end else begin
        // One-bit path: the captured zero leads, then the input bits.
        pipe.delete();
        pipe.push_back(1'b0);
        for (int b = 0; b < 16; b++) begin
          pipe.push_back(din[b]);
        end
        for (int b = 0; b < 16; b++) begin
          want[b] = pipe.pop_front();
        end
        chk(dout[15:0], want[15:0]);
      end
      $display("code %h done", codes[k]);
    end
    // Test reset in the middle of a data shift.
    i_host.idle(1'b1);
    repeat (5) i_host.idle(1'b0);
    chk(tdo_oe, 1'b1);
    i_host.set_trst(1'b0);
    repeat (3) @(negedge ref_clk_in);
    chk(instr_out, `IR_IDENT);
    chk(tdo_oe, 1'b0);
    i_host.set_trst(1'b1);
    i_host.idle(1'b0);
    i_host.scan(1'b0, 32, din, dout);
    chk(dout, id_exp);
    $display("reset test done");
    end_sim();
  end
endmodule
`default_nettype wire
